/* File: src/bridge_pwm_output_steering.sv */
// Timer time base, half/full-bridge PWM steering with dead band, Wishbone slave
//
// Functional notes
// [R1] Unscaled timer match sets the PWM period
// [R2] Half-bridge: A is PWM, B its complement
// [R3] Dead band delays each active edge
// [R4] Dead band beyond duty keeps output inactive
// [R5] Firmware sets both half-bridge pins as outputs
// [R6] Direction change applies at next period start
// [R7] Before boundary: modulated off, unmodulated swapped
// [R8] Swap leads boundary by 4 Tosc times prescale
// [R9] Prescaler divides by 1, 4 or 16
// [R10] Modulated outputs stay inactive until boundary
// [R11] Full-bridge inserts no dead band
// [R12] Full-bridge: one modulated, one held on
// [R13] Forward-to-reverse drops A and D, raises C
// [R14] Firmware reduces duty before reversing near full
// [R15] Count-period match feeds 4-bit postscaler
// [R16] Postscaler 1 to 16 sets match flag
// [R17] Timer counts prescaled, wraps after period match
// [R18] Forward: A on, D modulated; reverse: C, B
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module bridge_pwm_output_steering
    import bridge_pwm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             bridge_out_a_o,
    output logic             bridge_out_b_o,
    output logic             bridge_out_c_o,
    output logic             bridge_out_d_o,
    output logic             irq_o
);

    // Bus side state
    logic        ack_q;          // Single-cycle acknowledge
    logic [31:0] dat_q;          // Registered read data

    // Software visible registers
    logic [7:0]  count_q;        // Timer count
    logic [6:0]  ctl_q;          // Timer control
    logic [7:0]  period_q;       // Timer period
    logic        mode_q;         // Bridge mode, 1 = full bridge
    logic        dir_req_q;      // Requested direction, 1 = reverse
    logic [7:0]  duty_q;         // Duty length in timer counts
    logic [6:0]  deadband_q;     // Dead-band count
    logic [1:0]  irq_stat_q;     // Sticky event bits
    logic [1:0]  irq_mask_q;     // Event enables

    // Internal state
    logic        dir_q;          // Direction in force
    logic [3:0]  presc_cnt_q;    // Prescale counter
    logic [3:0]  post_cnt_q;     // Postscale counter
    logic [6:0]  db_cnt_q [2];   // Dead-band counters, A and B
    logic        out_a_q;        // Registered pin drivers
    logic        out_b_q;
    logic        out_c_q;
    logic        out_d_q;
    logic        irq_q;          // Registered interrupt

    // Bus decode
    wire         req       = cyc_i & stb_i & ~ack_q;
    wire         wr        = req & we_i & sel_i[0];
    wire [7:0]   wb        = dat_i[7:0];
    wire         wr_count  = wr & (adr_i == OFF_TIMER_COUNT);
    wire         wr_ctl    = wr & (adr_i == OFF_TIMER_CONTROL);
    wire         wr_period = wr & (adr_i == OFF_TIMER_PERIOD);
    wire         wr_bridge = wr & (adr_i == OFF_BRIDGE_CTRL);
    wire         wr_duty   = wr & (adr_i == OFF_DUTY);
    wire         wr_db     = wr & (adr_i == OFF_DEADBAND);
    wire         wr_stat   = wr & (adr_i == OFF_IRQ_STATUS);
    wire         wr_mask   = wr & (adr_i == OFF_IRQ_MASK);

    // Timer control fields
    wire [1:0]   ps_sel    = ctl_q[CTL_PS_MSB:CTL_PS_LSB];
    wire         timer_on  = ctl_q[CTL_ON_BIT];
    wire [3:0]   post_sel  = ctl_q[CTL_POST_MSB:CTL_POST_LSB];

    // Prescale terminal count; both upper codes divide by 16
    wire [3:0]   presc_max = (ps_sel == PS_DIV1) ? PRE_MAX_1 :
                             (ps_sel == PS_DIV4) ? PRE_MAX_4 : PRE_MAX_16; // [R9]

    // One prescaled timer step
    wire         tick      = timer_on & (presc_cnt_q == presc_max); // [R9]

    // Unscaled match, also the PWM period boundary
    wire         at_period = count_q == period_q;
    wire         match     = tick & at_period; // [R15] [R1]

    // Postscaled match event
    wire         post_fire = match & (post_cnt_q == post_sel); // [R16]

    // Direction change waiting for the boundary
    wire         full      = mode_q;
    wire         pending   = dir_req_q ^ dir_q;

    // Cycles left to the boundary inside the last count, and the lead window length
    wire [4:0]   cyc_left  = 5'(presc_max) - 5'(presc_cnt_q) + 5'h01;
    wire [4:0]   lead_len  = 5'(LEAD_CYC) * (5'(presc_max) + 5'h01); // [R8]

    // Changeover window just before the boundary
    wire         swap_win  = full & pending & timer_on & at_period
                             & (cyc_left <= lead_len); // [R7] [R8]

    // Raw modulation: active while count is below duty
    wire         pwm_raw   = timer_on & (count_q < duty_q); // [R1]

    // Dead-band sources: PWM and its complement, idle when timer stops
    wire [1:0]   db_src    = {timer_on & ~pwm_raw, pwm_raw}; // [R2]
    wire [1:0]   db_act;

    // Dead-band stage per half-bridge output
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_db
            // Delayed active level: source high and count reached
            assign db_act[g] = db_src[g] & (db_cnt_q[g] == deadband_q); // [R3] [R4]

            // Count cycles since the source turned active
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    db_cnt_q[g] <= RST_DB;
                end else if (!db_src[g]) begin
                    db_cnt_q[g] <= RST_DB; // [R4]
                end else if (db_cnt_q[g] != deadband_q) begin
                    db_cnt_q[g] <= db_cnt_q[g] + 7'h01; // [R3]
                end
            end
        end
    endgenerate

    // Full-bridge steering, no dead band
    wire         fwd       = ~dir_q;
    wire         fb_a      = timer_on & (swap_win ? ~dir_req_q : fwd);   // [R18] [R13]
    wire         fb_c      = timer_on & (swap_win ? dir_req_q : ~fwd);   // [R18] [R13]
    wire         fb_b      = ~swap_win & ~fwd & pwm_raw;  // [R11] [R12] [R10]
    wire         fb_d      = ~swap_win & fwd & pwm_raw;   // [R11] [R12] [R10]

    // Next pin levels by mode
    wire         out_a_d   = full ? fb_a : db_act[0]; // [R2]
    wire         out_b_d   = full ? fb_b : db_act[1]; // [R2]
    wire         out_c_d   = full & fb_c;             // [R2]
    wire         out_d_d   = full & fb_d;             // [R2]

    // Next timer count: software write, wrap on match, step on tick
    wire [7:0]   count_d   = wr_count ? wb :
                             match    ? RST_BYTE :
                             tick     ? count_q + 8'h01 : count_q; // [R17]

    // Next prescale counter
    wire [3:0]   presc_d   = (!timer_on || tick) ? RST_NIB : presc_cnt_q + 4'h1;

    // Next postscale counter
    wire [3:0]   post_d    = !match   ? post_cnt_q :
                             post_fire ? RST_NIB : post_cnt_q + 4'h1; // [R16]

    // Events and sticky status; a set wins over a write-one clear
    wire         dir_event = match & pending & full;
    wire [1:0]   events    = {dir_event, post_fire};
    wire [1:0]   clr_bits  = wr_stat ? wb[1:0] : RST_IRQ;
    wire [1:0]   irq_stat_d = (irq_stat_q & ~clr_bits) | events; // [R16]

    // Read mux, upper bits read as zero
    wire [7:0]   rd_byte   =
        (adr_i == OFF_TIMER_COUNT)   ? count_q :
        (adr_i == OFF_TIMER_CONTROL) ? {1'b0, ctl_q} :
        (adr_i == OFF_TIMER_PERIOD)  ? period_q :
        (adr_i == OFF_BRIDGE_CTRL)   ? {6'h00, dir_req_q, mode_q} :
        (adr_i == OFF_DUTY)          ? duty_q :
        (adr_i == OFF_DEADBAND)      ? {1'b0, deadband_q} :
        (adr_i == OFF_IRQ_STATUS)    ? {6'h00, irq_stat_q} :
        (adr_i == OFF_IRQ_MASK)      ? {6'h00, irq_mask_q} :
        (adr_i == OFF_BRIDGE_STATUS) ? {6'h00, pending, dir_q} : RST_BYTE;

    // Bus acknowledge and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    // Timer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q     <= RST_BYTE;
            presc_cnt_q <= RST_NIB;
            post_cnt_q  <= RST_NIB;
        end else begin
            count_q     <= count_d;     // [R17]
            presc_cnt_q <= presc_d;     // [R9]
            post_cnt_q  <= post_d;      // [R15]
        end
    end

    // Control registers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q      <= RST_CTL;
            period_q   <= RST_PERIOD;
            mode_q     <= 1'b0;
            dir_req_q  <= 1'b0;
            duty_q     <= RST_BYTE;
            deadband_q <= RST_DB;
            irq_mask_q <= RST_IRQ;
        end else begin
            // Timer control
            if (wr_ctl) begin
                ctl_q <= wb[6:0];
            end
            // Period
            if (wr_period) begin
                period_q <= wb;
            end
            // Mode and requested direction
            if (wr_bridge) begin
                mode_q    <= wb[BRG_MODE_BIT];
                dir_req_q <= wb[BRG_DIR_BIT]; // [R6]
            end
            // Duty
            if (wr_duty) begin
                duty_q <= wb;
            end
            // Dead band
            if (wr_db) begin
                deadband_q <= wb[6:0];
            end
            // Interrupt mask
            if (wr_mask) begin
                irq_mask_q <= wb[1:0];
            end
        end
    end

    // Direction in force changes only at a period boundary
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= 1'b0;
        end else if (match) begin
            dir_q <= dir_req_q; // [R6]
        end
    end

    // Sticky status and interrupt line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= RST_IRQ;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            out_c_q <= 1'b0;
            out_d_q <= 1'b0;
        end else begin
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
            out_c_q <= out_c_d;
            out_d_q <= out_d_d;
        end
    end

    // Outputs straight from flops
    assign dat_o          = dat_q;
    assign ack_o          = ack_q;
    assign bridge_out_a_o = out_a_q;
    assign bridge_out_b_o = out_b_q;
    assign bridge_out_c_o = out_c_q;
    assign bridge_out_d_o = out_d_q;
    assign irq_o          = irq_q;

endmodule

/* File: src/bridge_pwm_pkg.sv */
// Register map, field layout, reset values and timing constants of the bridge PWM block
package bridge_pwm_pkg;

    // Word offsets on the register bus (byte addresses)
    localparam logic [7:0] OFF_TIMER_COUNT   = 8'h00;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h04;
    localparam logic [7:0] OFF_TIMER_PERIOD  = 8'h08;
    localparam logic [7:0] OFF_BRIDGE_CTRL   = 8'h0C;
    localparam logic [7:0] OFF_DUTY          = 8'h10;
    localparam logic [7:0] OFF_DEADBAND      = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK      = 8'h1C;
    localparam logic [7:0] OFF_BRIDGE_STATUS = 8'h20;

    // Timer control fields
    localparam int CTL_PS_LSB   = 0;
    localparam int CTL_PS_MSB   = 1;
    localparam int CTL_ON_BIT   = 2;
    localparam int CTL_POST_LSB = 3;
    localparam int CTL_POST_MSB = 6;

    // Bridge control fields
    localparam int BRG_MODE_BIT = 0;
    localparam int BRG_DIR_BIT  = 1;

    // Interrupt status bits
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_DIR_BIT   = 1;

    // Prescale select codes and terminal counts of the prescale counter
    localparam logic [1:0] PS_DIV1     = 2'h0;
    localparam logic [1:0] PS_DIV4     = 2'h1;
    localparam logic [3:0] PRE_MAX_1   = 4'h0;
    localparam logic [3:0] PRE_MAX_4   = 4'h3;
    localparam logic [3:0] PRE_MAX_16  = 4'hF;

    // Reset values
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hFF;
    localparam logic [6:0] RST_CTL     = 7'h00;
    localparam logic [6:0] RST_DB      = 7'h00;
    localparam logic [3:0] RST_NIB     = 4'h0;
    localparam logic [1:0] RST_IRQ     = 2'h0;

    // Direction changeover lead: 4 oscillator periods per prescaled step
    localparam int TOSC_NS       = 25;
    localparam int CLK_PERIOD_NS = 100;
    localparam int LEAD_CYC      = (4 * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: verification/bridge_pwm_chk.sv */
// Port-level assertions for the bridge PWM block
`timescale 1ns/1ns
module bridge_pwm_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        bridge_out_a_o,
    input wire logic        bridge_out_b_o,
    input wire logic        bridge_out_c_o,
    input wire logic        bridge_out_d_o,
    input wire logic        irq_o
);
    // Short aliases for the four bridge pins
    wire a = bridge_out_a_o;
    wire b = bridge_out_b_o;
    wire c = bridge_out_c_o;
    wire d = bridge_out_d_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answer is one pulse, one cycle after the request
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    // Reset quiets every output, so it is watched through reset
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o
        && !(a || b || c || d)) else $error("outputs active after reset");
    // No bridge leg ever has both switches on, and the two modulated pins are never on together
    a_leg_ab: assert property (!(a && b))
        else $error("pins a and b both active");
    a_leg_cd: assert property (!(c && d))
        else $error("pins c and d both active");
    a_mod_pair: assert property (!(b && d))
        else $error("both modulated pins active");
    // At the changeover the modulated pair is off
    a_swap_rev: assert property ($fell(a) && $rose(c) |-> !b && !d)
        else $error("modulated pin active at reverse swap");
    a_swap_fwd: assert property ($fell(c) && $rose(a) |-> !b && !d)
        else $error("modulated pin active at forward swap");
endmodule

bind bridge_pwm_output_steering bridge_pwm_chk u_bridge_pwm_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .bridge_out_a_o(bridge_out_a_o), .bridge_out_b_o(bridge_out_b_o),
    .bridge_out_c_o(bridge_out_c_o), .bridge_out_d_o(bridge_out_d_o), .irq_o(irq_o)
);

/* File: verification/bridge_load_model.sv */
// Power stage model that latches any shoot-through on a bridge leg
`timescale 1ns/1ns
module bridge_load_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic c_i,
    input  wire logic d_i,
    output logic      fault_o
);
    // Firmware has made all four pins outputs, so every level is driven
    wire driven = 1'b1;
    // Both switches of one leg on at once
    wire shoot = (a_i & b_i) | (c_i & d_i);
    // Sticky fault flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_o <= 1'b0;
        end else if (shoot) begin
            fault_o <= 1'b1;
        end
    end
endmodule

/* File: verification/bridge_pwm_output_steering_tb.sv */
// Self-checking bench for the bridge PWM block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %0h exp %0h", $time, (g), (e)); end end
module bridge_pwm_output_steering_tb
    import bridge_pwm_pkg::*;
;
    typedef struct {logic [1:0] ps; logic m; logic dr; logic [7:0] du; logic [7:0] db;
        integer e[4];} row_s;
    // Prescale, mode, direction, duty, dead band, high clocks of a..d per period
    row_s rows[8] = '{'{2'h0, 1'h0, 1'h0, 8'h04, 8'h00, '{4, 6, 0, 0}},
        '{2'h0, 1'h0, 1'h0, 8'h06, 8'h02, '{4, 2, 0, 0}},
        '{2'h0, 1'h0, 1'h0, 8'h03, 8'h05, '{0, 2, 0, 0}},
        '{2'h0, 1'h1, 1'h0, 8'h03, 8'h05, '{10, 0, 0, 3}},
        '{2'h0, 1'h1, 1'h1, 8'h07, 8'h05, '{0, 7, 10, 0}},
        '{2'h1, 1'h0, 1'h0, 8'h04, 8'h00, '{16, 24, 0, 0}},
        '{2'h2, 1'h0, 1'h0, 8'h04, 8'h00, '{64, 96, 0, 0}},
        '{2'h3, 1'h1, 1'h0, 8'h02, 8'h00, '{160, 0, 0, 32}}};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h00000000;
    logic [7:0]  rq;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire         irq_o;
    wire         fault;
    wire  [3:0]  pins;
    integer      hi[4];
    integer      g;
    int          w;
    int          failures = 0;
    int          n_compared = 0;
    // 10 MHz clock
    always #50 clk_i = ~clk_i;
    bridge_pwm_output_steering u_bridge_pwm_output_steering (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .bridge_out_a_o(pins[0]), .bridge_out_b_o(pins[1]),
        .bridge_out_c_o(pins[2]), .bridge_out_d_o(pins[3]), .irq_o(irq_o));
    bridge_load_model u_bridge_load_model (.clk_i(clk_i), .rst_i(rst_i), .a_i(pins[0]),
        .b_i(pins[1]), .c_i(pins[2]), .d_i(pins[3]), .fault_o(fault));
    // Classic Wishbone single cycle; read data lands in rq
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= wr;
        adr <= a;
        dat <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rq = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic reset_dut;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(pins, 4'h0)
    endtask
    // Count high clocks of each pin over a window
    task automatic meas(input int n);
        hi = '{default: 0};
        repeat (n) begin
            @(negedge clk_i);
            foreach (hi[i]) hi[i] += pins[i];
        end
    endtask
    // Wait for a rising pin u, then count clocks until pin v is high
    task automatic gap(input int u, input int v);
        while (pins[u] !== 1'b0) @(negedge clk_i);
        while (pins[u] !== 1'b1) @(negedge clk_i);
        g = 0;
        while (pins[v] !== 1'b1) begin
            @(negedge clk_i);
            g++;
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        final_report();
    end
    initial begin
        reset_dut();
        bus(1'b0, OFF_TIMER_PERIOD, 8'h00);
        `CHK(rq, RST_PERIOD)
        bus(1'b1, OFF_TIMER_PERIOD, 8'h09);
        // Steady-state waveforms of every mode and prescale code
        foreach (rows[i]) begin
            bus(1'b1, OFF_TIMER_CONTROL, {6'h01, rows[i].ps});
            bus(1'b1, OFF_BRIDGE_CTRL, {6'h00, rows[i].dr, rows[i].m});
            bus(1'b1, OFF_DUTY, rows[i].du);
            bus(1'b1, OFF_DEADBAND, rows[i].db);
            w = 10 * (rows[i].ps == 2'h0 ? 1 : rows[i].ps == 2'h1 ? 4 : 16);
            repeat (2 * w) @(posedge clk_i);
            meas(w);
            foreach (hi[k]) begin
                `CHK(hi[k], rows[i].e[k])
            end
        end
        // Direction changeover at prescale 4, duty kept low before reversing
        bus(1'b1, OFF_TIMER_CONTROL, 8'h05);
        bus(1'b1, OFF_DUTY, 8'h05);
        bus(1'b1, OFF_IRQ_STATUS, 8'h03);
        gap(3, 3);
        bus(1'b1, OFF_BRIDGE_CTRL, 8'h03);
        bus(1'b0, OFF_BRIDGE_STATUS, 8'h00);
        `CHK(rq[1:0], 2'h2)
        gap(2, 1);
        `CHK(g, 4)
        bus(1'b0, OFF_IRQ_STATUS, 8'h00);
        `CHK(rq[IRQ_DIR_BIT], 1'b1)
        bus(1'b1, OFF_BRIDGE_CTRL, 8'h01);
        gap(0, 3);
        `CHK(g, 4)
        // Postscaled match every 16 periods, masked and cleared
        bus(1'b1, OFF_TIMER_CONTROL, 8'h7C);
        bus(1'b1, OFF_IRQ_STATUS, 8'h03);
        bus(1'b1, OFF_IRQ_MASK, 8'h01);
        while (irq_o !== 1'b1) @(negedge clk_i);
        bus(1'b1, OFF_IRQ_STATUS, 8'h03);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        repeat (100) @(negedge clk_i);
        bus(1'b0, OFF_IRQ_STATUS, 8'h00);
        `CHK(rq[IRQ_MATCH_BIT], 1'b0)
        repeat (70) @(negedge clk_i);
        bus(1'b0, OFF_IRQ_STATUS, 8'h00);
        `CHK(rq[IRQ_MATCH_BIT], 1'b1)
        `CHK(irq_o, 1'b1)
        bus(1'b1, OFF_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        `CHK(fault, 1'b0)
        // Reset in mid-run, then registers and an unmapped place
        reset_dut();
        bus(1'b0, OFF_TIMER_CONTROL, 8'h00);
        `CHK(rq, 8'h00)
        bus(1'b1, OFF_TIMER_COUNT, 8'h05);
        bus(1'b0, OFF_TIMER_COUNT, 8'h00);
        `CHK(rq, 8'h05)
        bus(1'b0, 8'h40, 8'h00);
        `CHK(rq, 8'h00)
        final_report();
    end
endmodule
